/* logic/wake_router_params.svh */
// Offsets, field positions, reset values and widths of the wake event router.
// Assumes byte addresses on an 8-bit register port with 32-bit data words.
`ifndef WAKE_ROUTER_PARAMS_SVH
`define WAKE_ROUTER_PARAMS_SVH

`define WR_ADDR_W          8
`define WR_DATA_W          32
`define WR_NUM_EVENTS      16
`define WR_ALARM_W         16
`define WR_MODE_W          2

// Register byte offsets
`define WR_OFF_EDGE_SEL    8'h00
`define WR_OFF_ENABLE      8'h04
`define WR_OFF_STATUS      8'h08
`define WR_OFF_IRQ_MASK    8'h0c
`define WR_OFF_WAKE_MASK   8'h10
`define WR_OFF_POWER_MODE  8'h14
`define WR_OFF_ALARM_LOAD  8'h18
`define WR_OFF_ALARM_CTRL  8'h1c
`define WR_OFF_ALARM_STATE 8'h20
`define WR_OFF_RAW_EVENTS  8'h24
`define WR_OFF_PENDING     8'h28

// Event bit positions
`define WR_EV_WAKE_PIN_LO  0
`define WR_EV_RESET_PIN    4
`define WR_EV_ALARM        5
`define WR_EV_RTC          6
`define WR_EV_WATCHDOG     7
`define WR_EV_BROWNOUT     8
`define WR_EV_CAN          9
`define WR_EV_QUAD         11
`define WR_EV_ETHERNET     12
`define WR_EV_USB          13
`define WR_EV_SCT          15

// Events that wake from every low-power mode
`define WR_DEEP_CLASS      16'h007f

// Alarm control and state fields
`define WR_ALARM_RUN_BIT   0
`define WR_ALARM_IE_BIT    1
`define WR_ALARM_STAT_BIT  16

// Reset values
`define WR_RST_EVENTS      16'h0000
`define WR_RST_ALARM       16'h0000
`define WR_RST_WORD        32'h0000_0000

`endif

/* logic/wake_router_pkg.sv */
// Types shared by the wake event router and its alarm counter.
// Assumes wake_router_params.svh is on the include path.
`include "wake_router_params.svh"

package wake_router_pkg;

	typedef enum logic [`WR_MODE_W-1:0] {
		MODE_SLEEP,
		MODE_DEEP_SLEEP,
		MODE_POWER_DOWN,
		MODE_DEEP_POWER_DOWN
	} power_mode_t;

	typedef struct packed {
		logic [`WR_ALARM_W-1:0] count;
		logic                   status;
	} alarm_state_t;

	typedef struct packed {
		logic [`WR_NUM_EVENTS-1:0] edge_sel;
		logic [`WR_NUM_EVENTS-1:0] enable;
		logic [`WR_NUM_EVENTS-1:0] status;
		logic [`WR_NUM_EVENTS-1:0] irq_mask;
		logic [`WR_NUM_EVENTS-1:0] wake_mask;
		logic [`WR_NUM_EVENTS-1:0] prev_in;
		power_mode_t               mode;
		logic                      alarm_run;
		logic                      alarm_ie;
		logic [`WR_DATA_W-1:0]     rd_data;
		logic                      irq;
		logic                      wake_core;
		logic                      wake_clock;
	} router_state_t;

endpackage : wake_router_pkg

/* logic/alarm_down_counter.sv */
// 16-bit alarm down-counter stepped by a 1 kHz tick with a sticky zero flag.
// Assumes tick is a one-cycle pulse synchronous to clk.
`include "wake_router_params.svh"

module alarm_down_counter (
	// Clock and reset
	input  wire logic                   clk,
	input  wire logic                   rst,
	// Control
	input  wire logic                   tick,
	input  wire logic                   run,
	input  wire logic                   load,
	input  wire logic [`WR_ALARM_W-1:0] preset,
	input  wire logic                   clear,
	// State
	output logic      [`WR_ALARM_W-1:0] count,
	output logic                        status
);

	wake_router_pkg::alarm_state_t cur;
	wake_router_pkg::alarm_state_t next_cur;

	always_comb begin
		next_cur = cur;
		if (clear) begin
			next_cur.status = 1'b0;
		end
		if (load) begin
			next_cur.count = preset;
		end else if (run && tick && cur.count != `WR_RST_ALARM) begin
			next_cur.count = cur.count - 16'h0001;  // [R7]
			// Set beats a same-cycle clear
			if (cur.count == 16'h0001) begin
				next_cur.status = 1'b1;  // [R8]
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			cur <= '{count: `WR_RST_ALARM, status: 1'b0};
		end else begin
			cur <= next_cur;
		end
	end

	assign count  = cur.count;
	assign status = cur.status;

endmodule : alarm_down_counter

/* logic/wake_event_router.sv */
// Wake event router: gathers wake pins, reset pin, alarm, RTC and peripheral events
// into one interrupt request and a wake-up request to the core and clock control unit.
// Assumes all inputs synchronous to clk and a one-cycle 1 kHz tick pulse.
//
// Behaviour
// R1: Enabled events merge into one interrupt request to the vectored interrupt ctrl.
// R2: Drive wake-up requests to core and clock control unit for all low-power modes.
// R3: Per-event edge/level choice and enable; disabled events cause nothing.
// R4: Wake pins, reset pin, alarm, running RTC wake from all four modes.
// R5: Watchdog, brownout, CAN, quadrature, Ethernet, USB, timer events wake sleep only.
// R6: Any controller-enabled peripheral interrupt wakes the core from sleep regardless.
// R7: Alarm is 16-bit, loaded with a preset, decremented each 1 kHz tick.
// R8: Alarm reaching zero sets its status; interrupts only when alarm interrupt enabled.
// R9: Captured status holds until software clears; level events re-assert while active.
`include "wake_router_params.svh"

module wake_event_router (
	// Clock and reset
	input  wire logic                  clk,
	input  wire logic                  rst,
	// Register port
	input  wire logic [`WR_ADDR_W-1:0] addr,
	input  wire logic [`WR_DATA_W-1:0] wr_data,
	input  wire logic                  wr_en,
	input  wire logic                  rd_en,
	output logic      [`WR_DATA_W-1:0] rd_data,
	// External event pins
	input  wire logic [3:0]            wake_pin,
	input  wire logic                  reset_pin,
	// Clock domain sources
	input  wire logic                  tick_1khz,
	input  wire logic                  rtc_event,
	input  wire logic                  rtc_osc_running,
	// Peripheral events
	input  wire logic                  windowed_watchdog,
	input  wire logic                  brownout_detector,
	input  wire logic [1:0]            can_controllers,
	input  wire logic                  quadrature_decoder,
	input  wire logic                  ethernet_event,
	input  wire logic [1:0]            usb_event,
	input  wire logic [1:0]            state_config_timer,
	// Peripheral interrupt enabled and pending in the controller
	input  wire logic                  periph_irq_pending,
	// Requests
	output logic                       vectored_interrupt_ctrl,
	output logic                       wake_core,
	output logic                       wake_clock_control_unit
);

	////////////////////////////////////////////////////////////////////////////////
	// State and event vector

	wake_router_pkg::router_state_t cur;
	wake_router_pkg::router_state_t next_cur;

	logic [`WR_NUM_EVENTS-1:0] events;
	logic [`WR_NUM_EVENTS-1:0] hit;
	logic [`WR_NUM_EVENTS-1:0] rising;
	logic [`WR_NUM_EVENTS-1:0] clear_mask;
	logic [`WR_NUM_EVENTS-1:0] live;
	logic [`WR_NUM_EVENTS-1:0] wake_ok;
	logic [`WR_ALARM_W-1:0]    alarm_count;
	logic                      alarm_status;
	logic                      alarm_load;
	logic                      alarm_clear;
	logic                      wr_hit;
	logic                      sleeping;

	////////////////////////////////////////////////////////////////////////////////
	// Alarm timer

	assign alarm_load  = wr_en && addr == `WR_OFF_ALARM_LOAD;
	assign alarm_clear = wr_en && addr == `WR_OFF_ALARM_STATE
		&& wr_data[`WR_ALARM_STAT_BIT];

	alarm_down_counter u_alarm (
		.clk    (clk),
		.rst    (rst),
		.tick   (tick_1khz),
		.run    (cur.alarm_run),
		.load   (alarm_load),
		.preset (wr_data[`WR_ALARM_W-1:0]),
		.clear  (alarm_clear),
		.count  (alarm_count),
		.status (alarm_status)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Event gathering

	always_comb begin
		events = `WR_RST_EVENTS;
		events[`WR_EV_WAKE_PIN_LO +: 4] = wake_pin;  // [R4]
		events[`WR_EV_RESET_PIN]         = reset_pin;  // [R4]
		// Alarm reaches the router only with its own interrupt enabled
		events[`WR_EV_ALARM]             = alarm_status && cur.alarm_ie;  // [R8]
		// RTC stops counting without its oscillator, so its event is gated
		events[`WR_EV_RTC]               = rtc_event && rtc_osc_running;  // [R4]
		events[`WR_EV_WATCHDOG]          = windowed_watchdog;  // [R5]
		events[`WR_EV_BROWNOUT]          = brownout_detector;  // [R5]
		events[`WR_EV_CAN +: 2]          = can_controllers;  // [R5]
		events[`WR_EV_QUAD]              = quadrature_decoder;  // [R5]
		events[`WR_EV_ETHERNET]          = ethernet_event;  // [R5]
		events[`WR_EV_USB +: 2]          = usb_event;  // [R5]
		events[`WR_EV_SCT]               = |state_config_timer;  // [R5]
	end

	// Rising edge for edge events, plain level otherwise
	assign rising = events & ~cur.prev_in;
	assign hit    = ((cur.edge_sel & rising) | (~cur.edge_sel & events)) & cur.enable;  // [R3]

	assign wr_hit     = wr_en && addr == `WR_OFF_STATUS;
	assign clear_mask = wr_hit ? wr_data[`WR_NUM_EVENTS-1:0] : `WR_RST_EVENTS;

	// A captured bit only counts while its event stays enabled
	assign live = cur.status & cur.enable;  // [R3]

	// Sleep-only sources lose their wake power in deeper modes
	assign sleeping = cur.mode == wake_router_pkg::MODE_SLEEP;
	assign wake_ok  = sleeping ? {`WR_NUM_EVENTS{1'b1}} : `WR_DEEP_CLASS;  // [R4] [R5]

	////////////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb begin
		next_cur         = cur;
		next_cur.prev_in = events;
		next_cur.rd_data = `WR_RST_WORD;

		// Set wins over a same-cycle write-one clear
		next_cur.status = (cur.status & ~clear_mask) | hit;  // [R9]

		if (wr_en) begin
			case (addr)
				`WR_OFF_EDGE_SEL: begin
					next_cur.edge_sel = wr_data[`WR_NUM_EVENTS-1:0];  // [R3]
				end
				`WR_OFF_ENABLE: begin
					next_cur.enable = wr_data[`WR_NUM_EVENTS-1:0];  // [R3]
				end
				`WR_OFF_IRQ_MASK: begin
					next_cur.irq_mask = wr_data[`WR_NUM_EVENTS-1:0];
				end
				`WR_OFF_WAKE_MASK: begin
					next_cur.wake_mask = wr_data[`WR_NUM_EVENTS-1:0];
				end
				`WR_OFF_POWER_MODE: begin
					next_cur.mode = wake_router_pkg::power_mode_t'(wr_data[`WR_MODE_W-1:0]);
				end
				`WR_OFF_ALARM_CTRL: begin
					next_cur.alarm_run = wr_data[`WR_ALARM_RUN_BIT];  // [R7]
					next_cur.alarm_ie  = wr_data[`WR_ALARM_IE_BIT];  // [R8]
				end
				default: begin
				end
			endcase
		end

		if (rd_en) begin
			case (addr)
				`WR_OFF_EDGE_SEL: begin
					next_cur.rd_data[`WR_NUM_EVENTS-1:0] = cur.edge_sel;
				end
				`WR_OFF_ENABLE: begin
					next_cur.rd_data[`WR_NUM_EVENTS-1:0] = cur.enable;
				end
				`WR_OFF_STATUS: begin
					next_cur.rd_data[`WR_NUM_EVENTS-1:0] = cur.status;
				end
				`WR_OFF_IRQ_MASK: begin
					next_cur.rd_data[`WR_NUM_EVENTS-1:0] = cur.irq_mask;
				end
				`WR_OFF_WAKE_MASK: begin
					next_cur.rd_data[`WR_NUM_EVENTS-1:0] = cur.wake_mask;
				end
				`WR_OFF_POWER_MODE: begin
					next_cur.rd_data[`WR_MODE_W-1:0] = cur.mode;
				end
				`WR_OFF_ALARM_CTRL: begin
					next_cur.rd_data[`WR_ALARM_RUN_BIT] = cur.alarm_run;
					next_cur.rd_data[`WR_ALARM_IE_BIT]  = cur.alarm_ie;
				end
				`WR_OFF_ALARM_STATE: begin
					next_cur.rd_data[`WR_ALARM_W-1:0]     = alarm_count;
					next_cur.rd_data[`WR_ALARM_STAT_BIT] = alarm_status;
				end
				`WR_OFF_RAW_EVENTS: begin
					next_cur.rd_data[`WR_NUM_EVENTS-1:0] = events;
				end
				`WR_OFF_PENDING: begin
					next_cur.rd_data[`WR_NUM_EVENTS-1:0] = live;
				end
				default: begin
					// Unmapped and write-only offsets read as zero
					next_cur.rd_data = `WR_RST_WORD;
				end
			endcase
		end

		// Outputs follow the current status, one cycle behind
		next_cur.irq = |(live & cur.irq_mask);  // [R1]
		// Controller-enabled interrupts wake the core from sleep on their own
		next_cur.wake_core  = |(live & cur.wake_mask & wake_ok)
			|| (sleeping && periph_irq_pending);  // [R2] [R6]
		// Clock control unit only needs router events; sleep keeps clocks alive
		next_cur.wake_clock = |(live & cur.wake_mask & wake_ok);  // [R2]
	end

	////////////////////////////////////////////////////////////////////////////////
	// Registers

	always_ff @(posedge clk) begin
		if (rst) begin
			cur <= '{
				edge_sel:   `WR_RST_EVENTS,
				enable:     `WR_RST_EVENTS,
				status:     `WR_RST_EVENTS,
				irq_mask:   `WR_RST_EVENTS,
				wake_mask:  `WR_RST_EVENTS,
				prev_in:    `WR_RST_EVENTS,
				mode:       wake_router_pkg::MODE_SLEEP,
				alarm_run:  1'b0,
				alarm_ie:   1'b0,
				rd_data:    `WR_RST_WORD,
				irq:        1'b0,
				wake_core:  1'b0,
				wake_clock: 1'b0
			};
		end else begin
			cur <= next_cur;
		end
	end

	assign rd_data                 = cur.rd_data;
	assign vectored_interrupt_ctrl = cur.irq;
	assign wake_core               = cur.wake_core;
	assign wake_clock_control_unit = cur.wake_clock;

endmodule : wake_event_router

/* bench/vic_model.sv */
// Model of the interrupt controller and clock control unit facing the router.
// Assumes the bench commands when a peripheral interrupt is pending.
module vic_model (
	// Clock and reset
	input  wire logic clk,
	input  wire logic rst,
	// Bench command
	input  wire logic raise,
	// Requests from the router
	input  wire logic irq,
	input  wire logic wake_core,
	input  wire logic wake_clock,
	// Pending to the router, woke flag to the bench
	output logic      pending,
	output logic      woke
);
	timeunit 1ns;
	timeprecision 1ps;
	// Pending is registered, as a real controller flag would be
	always_ff @(posedge clk) begin
		if (rst) begin
			pending <= 1'b0;
			woke    <= 1'b0;
		end else begin
			pending <= raise;
			woke    <= woke | wake_core | wake_clock | irq;
		end
	end
endmodule : vic_model

/* bench/wake_router_sva.sv */
// Port assertions for the wake event router.
// Assumes one clock and the synchronous reset rst.
`include "wake_router_params.svh"

module wake_router_sva (
	// Clock and reset
	input  wire logic                  clk,
	input  wire logic                  rst,
	// Register port
	input  wire logic [`WR_ADDR_W-1:0] addr,
	input  wire logic                  wr_en,
	input  wire logic                  rd_en,
	input  wire logic [`WR_DATA_W-1:0] rd_data,
	// Requests
	input  wire logic                  periph_irq_pending,
	input  wire logic                  vectored_interrupt_ctrl,
	input  wire logic                  wake_core,
	input  wire logic                  wake_clock_control_unit
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	////////////////////////////////////////////////////////////////////////
	chk_reset_quiet: assert property ($fell(rst) |-> !vectored_interrupt_ctrl && !wake_core)
		else $error("request high after reset");
	chk_read_idle: assert property (!$past(rd_en) |-> rd_data == 32'h0)
		else $error("read data outside read cycle");
	chk_wake_pair: assert property (wake_clock_control_unit |-> wake_core)
		else $error("clock wake without core wake");
	chk_core_cause: assert property (wake_core && !wake_clock_control_unit |-> $past(periph_irq_pending))
		else $error("core wake without cause");
	chk_irq_sticky: assert property ($fell(vectored_interrupt_ctrl) |-> $past(wr_en, 2))
		else $error("interrupt dropped without write");
	chk_wake_sticky: assert property ($fell(wake_clock_control_unit) |-> $past(wr_en, 2))
		else $error("wake dropped without write");
	chk_mode_read: assert property (rd_en && addr == `WR_OFF_POWER_MODE |=> rd_data[31:2] == 30'h0)
		else $error("mode upper bits set");
	chk_edge_read: assert property (rd_en && addr == `WR_OFF_EDGE_SEL |=> rd_data[31:16] == 16'h0)
		else $error("edge select upper bits set");
	chk_unmapped: assert property (rd_en && addr == 8'h2c |=> rd_data == 32'h0)
		else $error("unmapped read not zero");
endmodule : wake_router_sva

bind wake_event_router wake_router_sva u_sva (.clk(clk), .rst(rst), .addr(addr),
	.wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .periph_irq_pending(periph_irq_pending),
	.vectored_interrupt_ctrl(vectored_interrupt_ctrl), .wake_core(wake_core),
	.wake_clock_control_unit(wake_clock_control_unit));

/* bench/wake_event_router_tb.sv */
// Self-checking bench for the wake event router.
// Assumes design files compiled first; one 250 MHz clock.
`include "wake_router_params.svh"

module wake_event_router_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk = 0, rst = 1, wr_en = 0, rd_en = 0, tick = 0;
	logic        osc = 1, raise = 0, irq, wcore, wclk, pend, woke;
	logic [7:0]  addr = 8'h00;
	logic [31:0] wdat = 32'h0, rdat, d;
	logic [15:0] ev = 16'h0;
	int          errors = 0, n_tests = 0;
	always #2 clk = ~clk;
	wake_event_router dut (.clk(clk), .rst(rst), .addr(addr), .wr_data(wdat), .wr_en(wr_en),
		.rd_en(rd_en), .rd_data(rdat), .wake_pin(ev[3:0]), .reset_pin(ev[4]),
		.tick_1khz(tick), .rtc_event(ev[6]), .rtc_osc_running(osc), .windowed_watchdog(ev[7]),
		.brownout_detector(ev[8]), .can_controllers(ev[10:9]), .quadrature_decoder(ev[11]),
		.ethernet_event(ev[12]), .usb_event(ev[14:13]), .state_config_timer({1'b0, ev[15]}),
		.periph_irq_pending(pend), .vectored_interrupt_ctrl(irq), .wake_core(wcore),
		.wake_clock_control_unit(wclk));
	vic_model u_vic (.clk(clk), .rst(rst), .raise(raise), .irq(irq), .wake_core(wcore),
		.wake_clock(wclk), .pending(pend), .woke(woke));
	////////////////////////////////////////////////////////////////////////
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk);
		addr  <= a;
		wdat  <= v;
		wr_en <= 1'b1;
		@(posedge clk);
		wr_en <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge clk);
		addr  <= a;
		rd_en <= 1'b1;
		@(posedge clk);
		rd_en <= 1'b0;
		@(negedge clk);
		v = rdat;
	endtask : rd
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_tests++;
		if (g !== e) begin
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
			errors++;
		end
	endtask : chk
	// Ends off the edge so outputs are settled
	task automatic idle(input int n);
		repeat (n) @(posedge clk);
		@(negedge clk);
	endtask : idle
	task automatic setin(input logic [15:0] v);
		@(posedge clk);
		ev <= v;
	endtask : setin
	task automatic pulse;
		@(posedge clk);
		tick <= 1'b1;
		@(posedge clk);
		tick <= 1'b0;
	endtask : pulse
	////////////////////////////////////////////////////////////////////////
	task automatic t_reset;
		for (int a = 0; a <= 8'h2c; a += 4) begin
			rd(8'(a), d);
			chk(d, 32'h0);
		end
	endtask : t_reset
	task automatic t_edge_level;
		wr(`WR_OFF_EDGE_SEL, 32'h1);
		wr(`WR_OFF_ENABLE, 32'h3);
		wr(`WR_OFF_IRQ_MASK, 32'h3);
		setin(16'h0001);
		idle(4);
		chk(32'(irq), 32'h1);
		wr(`WR_OFF_STATUS, 32'h1);
		idle(3);
		chk(32'(irq), 32'h0);
		setin(16'h0002);
		idle(4);
		wr(`WR_OFF_STATUS, 32'h2);
		idle(3);
		rd(`WR_OFF_STATUS, d);
		chk(d, 32'h2);
		setin(16'h0004);
		wr(`WR_OFF_STATUS, 32'h2);
		idle(4);
		chk(32'(irq), 32'h0);
		rd(`WR_OFF_RAW_EVENTS, d);
		chk(d, 32'h4);
		setin(16'h0);
	endtask : t_edge_level
	// Level mode, every source but the alarm in every mode
	task automatic t_modes;
		wr(`WR_OFF_EDGE_SEL, 32'h0);
		wr(`WR_OFF_ENABLE, 32'hffff);
		wr(`WR_OFF_WAKE_MASK, 32'hffff);
		for (int m = 0; m < 4; m++) begin
			wr(`WR_OFF_POWER_MODE, 32'(m));
			for (int b = 0; b < 16; b++) begin
				if (b == 5) continue;
				setin(16'h1 << b);
				idle(4);
				chk(32'(wclk), 32'((m == 0) || (b < 7)));
				setin(16'h0);
				wr(`WR_OFF_STATUS, 32'hffff);
				idle(2);
			end
		end
	endtask : t_modes
	task automatic t_periph;
		wr(`WR_OFF_ENABLE, 32'h0);
		wr(`WR_OFF_POWER_MODE, 32'h0);
		@(posedge clk);
		raise <= 1'b1;
		idle(3);
		chk(32'(wcore), 32'h1);
		chk(32'(wclk), 32'h0);
		wr(`WR_OFF_POWER_MODE, 32'h1);
		idle(3);
		chk(32'(wcore), 32'h0);
		chk(32'(woke), 32'h1);
		@(posedge clk);
		raise <= 1'b0;
	endtask : t_periph
	task automatic t_alarm;
		wr(`WR_OFF_ENABLE, 32'h20);
		wr(`WR_OFF_IRQ_MASK, 32'h20);
		wr(`WR_OFF_ALARM_LOAD, 32'h3);
		wr(`WR_OFF_ALARM_CTRL, 32'h3);
		pulse;
		rd(`WR_OFF_ALARM_STATE, d);
		chk(d, 32'h2);
		chk(32'(irq), 32'h0);
		pulse;
		pulse;
		idle(4);
		rd(`WR_OFF_ALARM_STATE, d);
		chk(d, 32'h10000);
		chk(32'(irq), 32'h1);
		wr(`WR_OFF_ALARM_STATE, 32'h10000);
		wr(`WR_OFF_STATUS, 32'h20);
		idle(3);
		chk(32'(irq), 32'h0);
		// Alarm interrupt disabled: status still sets, no request
		wr(`WR_OFF_ALARM_LOAD, 32'h1);
		wr(`WR_OFF_ALARM_CTRL, 32'h1);
		pulse;
		idle(4);
		rd(`WR_OFF_ALARM_STATE, d);
		chk(d, 32'h10000);
		chk(32'(irq), 32'h0);
		wr(`WR_OFF_ALARM_STATE, 32'h10000);
	endtask : t_alarm
	// RTC only counts with its oscillator; disabled bits stay hidden
	task automatic t_rtc_gate;
		wr(`WR_OFF_ENABLE, 32'h40);
		@(posedge clk);
		osc <= 1'b0;
		setin(16'h0040);
		idle(4);
		rd(`WR_OFF_STATUS, d);
		chk(d, 32'h0);
		@(posedge clk);
		osc <= 1'b1;
		idle(4);
		rd(`WR_OFF_STATUS, d);
		chk(d, 32'h40);
		chk(32'(wcore), 32'h1);
		chk(32'(wclk), 32'h1);
		wr(`WR_OFF_ENABLE, 32'h0);
		rd(`WR_OFF_PENDING, d);
		chk(d, 32'h0);
		setin(16'h0);
		wr(`WR_OFF_STATUS, 32'h40);
	endtask : t_rtc_gate
	task automatic wrap_up;
		$display("errors=%0d n_tests=%0d", errors, n_tests);
		if (errors == 0 && n_tests > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : wrap_up
	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		t_reset;
		t_edge_level;
		t_modes;
		t_periph;
		t_alarm;
		t_rtc_gate;
		wrap_up;
	end
	// About twenty-five times the expected run
	initial begin
		repeat (20000) @(posedge clk);
		errors++;
		wrap_up;
	end
endmodule : wake_event_router_tb
